/* File: hdl/pia_pkg.sv */
package pia_pkg;

  // mask and level encoding
  localparam int          MASK_W        = 3;
  localparam logic [2:0]  LVL_NMI       = 3'h7;   // fixed level of the non-maskable entry
  localparam logic [2:0]  LVL_TOP_MASKB = 3'h6;   // highest level a maskable source may hold
  localparam logic [2:0]  LVL_OFF       = 3'h0;   // level that never wins
  localparam logic [2:0]  MASK_RESET    = 3'h7;   // mask value after reset
  localparam logic [2:0]  MASK_ALL      = 3'h7;   // mask value loaded by the mask-all instruction

  // vector numbering
  localparam logic [7:0]  VEC_NMI       = 8'h20;  // vector of the non-maskable entry
  localparam logic [7:0]  VEC_CHAN_BASE = 8'h28;  // vector of maskable channel 0
  localparam logic [7:0]  VEC_CHAN_STEP = 8'h04;  // vector spacing between channels
  localparam logic [7:0]  DMA_VEC_RESET = 8'h00;  // transfer-engine start vector after reset

  // vector table: 256 bytes at the top of a 24-bit space
  localparam logic [15:0] VEC_TABLE_HI  = 16'hffff;

  // acceptance length in states, by stack bus / vector bus width
  localparam int          CNT_W         = 6;
  localparam logic [5:0]  STATES_S8_V8  = 6'h23;  // 35
  localparam logic [5:0]  STATES_S8_V16 = 6'h1f;  // 31
  localparam logic [5:0]  STATES_S16_V8 = 6'h1d;  // 29
  localparam logic [5:0]  STATES_S16_V16 = 6'h19; // 25

  // defaults for the top module parameters
  localparam int          N_CHAN_DEF    = 22;
  localparam int          NEST_W_DEF    = 8;

  // sequencer states
  typedef enum logic [0:0] {
    PIA_IDLE,
    PIA_SEQ
  } pia_state_e;

endpackage : pia_pkg

/* File: hdl/pia_arb_if.sv */
`timescale 1ns/1ps
// pending requests in, single winner out
interface pia_arb_if #(
  parameter int E  = 23,
  parameter int IW = $clog2(E)
);
  logic [E-1:0]       req;        // latched requests
  logic [E-1:0][2:0]  lvl;        // per-entry level
  logic               win_valid;  // some entry competes
  logic [IW-1:0]      win_idx;    // winning entry
  logic [2:0]         win_lvl;    // winning level

  modport arb  (input req, lvl, output win_valid, win_idx, win_lvl);
  modport user (output req, lvl, input win_valid, win_idx, win_lvl);
endinterface : pia_arb_if

/* File: hdl/pia_prio_tree.sv */
`timescale 1ns/1ps
// highest level wins; on a tie the lowest index (smallest vector) wins
module pia_prio_tree #(
  parameter int E  = 23,
  parameter int IW = $clog2(E)
) (
  pia_arb_if.arb a
);

  logic          found;     // any requesting entry with a nonzero level
  logic [2:0]    best_lvl;  // running best level
  logic [IW-1:0] best_idx;  // running best index

  // scan downward so a lower index overrides an equal level
  always_comb begin
    found    = 1'b0;
    best_lvl = pia_pkg::LVL_OFF;
    best_idx = '0;
    for (int i = E - 1; i >= 0; i--) begin
      if (a.req[i] && (a.lvl[i] != pia_pkg::LVL_OFF) && (a.lvl[i] >= best_lvl)) begin
        found    = 1'b1;
        best_lvl = a.lvl[i];
        best_idx = IW'(i);
      end
    end
  end

  assign a.win_valid = found;
  assign a.win_idx   = best_idx;
  assign a.win_lvl   = best_lvl;

endmodule : pia_prio_tree

/* File: hdl/pia_top.sv */
`timescale 1ns/1ps
module pia_top #(
  parameter int N_CHAN = pia_pkg::N_CHAN_DEF,
  parameter int NEST_W = pia_pkg::NEST_W_DEF,
  parameter int CW     = $clog2(N_CHAN)
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              nmi_req,
  input  wire logic [N_CHAN-1:0] chan_req,
  input  wire logic              cfg_we,
  input  wire logic [CW-1:0]     cfg_chan,
  input  wire logic [2:0]        cfg_level,
  input  wire logic [7:0]        cfg_dma_vec,
  input  wire logic              clr_we,
  input  wire logic [CW-1:0]     clr_chan,
  input  wire logic              mask_set_instr,
  input  wire logic [2:0]        mask_set_value,
  input  wire logic              mask_all_instr,
  input  wire logic              software_trap_instr,
  input  wire logic [7:0]        trap_vector,
  input  wire logic              return_from_interrupt_instr,
  input  wire logic [2:0]        return_mask_value,
  input  wire logic              stack_bus16,
  input  wire logic              vector_bus16,
  output logic                   irq_request,
  output logic [2:0]             irq_level,
  output logic [2:0]             cpu_interrupt_mask,
  output logic [NEST_W-1:0]      interrupt_nesting_counter,
  output logic                   vector_ack,
  output logic [7:0]             vector_value,
  output logic [7:0]             dma_start_vector,
  output logic                   stack_push,
  output logic                   stack_pop,
  output logic                   accept_busy,
  output logic                   handler_go,
  output logic [23:0]            handler_addr
);

  localparam int E  = N_CHAN + 1;   // entry 0 is the non-maskable source
  localparam int IW = $clog2(E);

  ////////////////////////////////////////////////////////////////////////////
  // channel state

  logic [E-1:0]            req_reg;   // request latches
  logic [E-1:0]            req_next;
  logic [E-1:0][2:0]       lvl_reg;   // programmed levels
  logic [E-1:0][2:0]       lvl_next;
  logic [N_CHAN-1:0][7:0]  dmav_reg;  // transfer-engine start vectors
  logic [N_CHAN-1:0][7:0]  dmav_next;
  logic [E-1:0]            set_vec;   // incoming request pulses per entry
  logic                    take_irq;  // winner delivered this cycle

  pia_arb_if #(.E(E), .IW(IW)) arb_bus ();  // carrier ahead of its readers
  assign set_vec = {chan_req, nmi_req};

  // latch, level and start-vector per channel; set beats any clear
  always_comb begin
    req_next  = req_reg;
    lvl_next  = lvl_reg;
    dmav_next = dmav_reg;
    for (int i = 0; i < E; i++) begin
      // delivery clears the winner only
      if (take_irq && (arb_bus.win_idx == IW'(i))) begin
        req_next[i] = 1'b0;
      end
      // software clear reaches maskable channels only
      if (clr_we && (i > 0) && (clr_chan == CW'(i - 1))) begin
        req_next[i] = 1'b0;
      end
      if (set_vec[i]) begin
        req_next[i] = 1'b1;
      end
    end
    if (cfg_we) begin
      // 7 belongs to the non-maskable entry; a maskable 7 is parked as off
      lvl_next[cfg_chan + 1] = (cfg_level > pia_pkg::LVL_TOP_MASKB) ?
                               pia_pkg::LVL_OFF : cfg_level;
      dmav_next[cfg_chan]    = cfg_dma_vec;
    end
    lvl_next[0] = pia_pkg::LVL_NMI;
  end

  // register the channel state
  always_ff @(posedge clk) begin
    if (!resetn) begin
      req_reg  <= '0;
      lvl_reg  <= '0;
      dmav_reg <= '0;
    end else begin
      req_reg  <= req_next;
      lvl_reg  <= lvl_next;
      dmav_reg <= dmav_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbitration

  assign arb_bus.req = req_reg;
  assign arb_bus.lvl = lvl_reg;

  pia_prio_tree #(.E(E), .IW(IW)) u_tree (
    .a (arb_bus)
  );

  // vector number of an entry
  function automatic logic [7:0] entry_vec(input logic [IW-1:0] idx);
    if (idx == '0) begin
      entry_vec = pia_pkg::VEC_NMI;
    end else begin
      entry_vec = 8'(int'(pia_pkg::VEC_CHAN_BASE) +
                     int'(pia_pkg::VEC_CHAN_STEP) * (int'(idx) - 1));
    end
  endfunction : entry_vec

  ////////////////////////////////////////////////////////////////////////////
  // acceptance sequencer

  pia_pkg::pia_state_e  state_reg, state_next;
  logic [5:0]           cnt_reg, cnt_next;     // states left in the sequence
  logic [2:0]           mask_reg, mask_next;
  logic [NEST_W-1:0]    nest_reg, nest_next;
  logic [7:0]           vec_reg, vec_next;     // vector of the running acceptance
  logic [2:0]           plvl_reg, plvl_next;
  logic                 preq_reg, preq_next;
  logic                 ack_reg, ack_next;
  logic [7:0]           ackv_reg, ackv_next;
  logic [7:0]           dmao_reg, dmao_next;
  logic                 push_reg, push_next;
  logic                 pop_reg, pop_next;
  logic                 hgo_reg, hgo_next;
  logic [23:0]          haddr_reg, haddr_next;

  logic       idle;
  logic       seq_end;
  logic       accept_ok;   // winner beats the mask
  logic       instr_any;
  logic       take_trap;
  logic       do_set;
  logic       do_all;
  logic       do_return_from_interrupt_instr;
  logic [5:0] seq_len;     // states for the current bus widths
  logic [2:0] mask_after;  // mask after a maskable acceptance

  assign idle    = (state_reg == pia_pkg::PIA_IDLE);
  assign seq_end = (state_reg == pia_pkg::PIA_SEQ) && (cnt_reg == '0);

  // strict compare keeps same-level requests out; level 7 always passes
  assign accept_ok = arb_bus.win_valid &&
                     ((arb_bus.win_lvl > mask_reg) ||
                      (arb_bus.win_lvl == pia_pkg::LVL_NMI));

  // instructions only happen between acceptances; an instruction cycle
  // defers a pending request by one cycle (after a trap: to the end of its sequence) rather than racing it
  assign instr_any = software_trap_instr | mask_set_instr | mask_all_instr |
                     return_from_interrupt_instr;
  assign take_trap = idle && software_trap_instr;
  assign take_irq  = accept_ok && ((idle && !instr_any) || seq_end);
  assign do_set    = idle && mask_set_instr && !software_trap_instr;
  assign do_all    = idle && mask_all_instr && !software_trap_instr && !mask_set_instr;
  assign do_return_from_interrupt_instr   = idle && return_from_interrupt_instr && !software_trap_instr &&
                     !mask_set_instr && !mask_all_instr;

  assign seq_len = stack_bus16 ?
                   (vector_bus16 ? pia_pkg::STATES_S16_V16 : pia_pkg::STATES_S16_V8) :
                   (vector_bus16 ? pia_pkg::STATES_S8_V16  : pia_pkg::STATES_S8_V8);

  // level plus one, held at 7
  assign mask_after = (arb_bus.win_lvl >= pia_pkg::LVL_TOP_MASKB) ?
                      pia_pkg::MASK_ALL : (arb_bus.win_lvl + 3'h1);

  // next values of the sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    mask_next  = mask_reg;
    nest_next  = nest_reg;
    vec_next   = vec_reg;
    ackv_next  = ackv_reg;
    dmao_next  = dmao_reg;
    haddr_next = haddr_reg;
    ack_next   = 1'b0;
    push_next  = 1'b0;
    pop_next   = 1'b0;
    hgo_next   = 1'b0;
    plvl_next  = arb_bus.win_valid ? arb_bus.win_lvl : pia_pkg::LVL_OFF;
    preq_next  = accept_ok;
    unique case (state_reg)
      pia_pkg::PIA_IDLE: begin
        if (do_set) begin
          mask_next = mask_set_value;
        end else if (do_all) begin
          mask_next = pia_pkg::MASK_ALL;
        end else if (do_return_from_interrupt_instr) begin
          // status register comes back from the stack with its mask
          pop_next  = 1'b1;
          mask_next = return_mask_value;
          if (nest_reg != '0) begin
            nest_next = nest_reg - 1'b1;
          end
        end
      end
      pia_pkg::PIA_SEQ: begin
        if (cnt_reg != '0) begin
          cnt_next = cnt_reg - 1'b1;
        end else if (!take_irq) begin
          // branch through the table entry of the captured vector
          hgo_next   = 1'b1;
          haddr_next = {pia_pkg::VEC_TABLE_HI, vec_reg};
          state_next = pia_pkg::PIA_IDLE;
        end
      end
    endcase
    // start (or nested restart) of an acceptance
    if (take_trap || take_irq) begin
      state_next = pia_pkg::PIA_SEQ;
      cnt_next   = seq_len - 6'h01;
      push_next  = 1'b1;
      if (nest_reg != '1) begin
        nest_next = nest_reg + 1'b1;
      end
      if (take_trap) begin
        vec_next = trap_vector;
      end else begin
        vec_next  = entry_vec(arb_bus.win_idx);
        ackv_next = entry_vec(arb_bus.win_idx);
        ack_next  = 1'b1;
        dmao_next = (arb_bus.win_idx == '0) ? pia_pkg::DMA_VEC_RESET :
                    dmav_reg[arb_bus.win_idx - 1'b1];
        mask_next = mask_after;
      end
    end
  end

  // register the sequencer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= pia_pkg::PIA_IDLE;
      cnt_reg   <= '0;
      mask_reg  <= pia_pkg::MASK_RESET;
      nest_reg  <= '0;
      vec_reg   <= '0;
      plvl_reg  <= pia_pkg::LVL_OFF;
      preq_reg  <= 1'b0;
      ack_reg   <= 1'b0;
      ackv_reg  <= '0;
      dmao_reg  <= pia_pkg::DMA_VEC_RESET;
      push_reg  <= 1'b0;
      pop_reg   <= 1'b0;
      hgo_reg   <= 1'b0;
      haddr_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      mask_reg  <= mask_next;
      nest_reg  <= nest_next;
      vec_reg   <= vec_next;
      plvl_reg  <= plvl_next;
      preq_reg  <= preq_next;
      ack_reg   <= ack_next;
      ackv_reg  <= ackv_next;
      dmao_reg  <= dmao_next;
      push_reg  <= push_next;
      pop_reg   <= pop_next;
      hgo_reg   <= hgo_next;
      haddr_reg <= haddr_next;
    end
  end

  // outputs straight from flops
  assign irq_request               = preq_reg;
  assign irq_level                 = plvl_reg;
  assign cpu_interrupt_mask        = mask_reg;
  assign interrupt_nesting_counter = nest_reg;
  assign vector_ack                = ack_reg;
  assign vector_value              = ackv_reg;
  assign dma_start_vector          = dmao_reg;
  assign stack_push                = push_reg;
  assign stack_pop                 = pop_reg;
  assign accept_busy               = (state_reg == pia_pkg::PIA_SEQ);
  assign handler_go                = hgo_reg;
  assign handler_addr              = haddr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_reset_mask: assert property (
    disable iff (1'b0) !resetn |=> (mask_reg == pia_pkg::MASK_RESET))
    else $error("mask not 7 after reset");

  chk_mask_set_now: assert property (do_set |=>
    (mask_reg == $past(mask_set_value)))
    else $error("mask-set operand not loaded next cycle");

  chk_mask_all_7: assert property (do_all |=> (mask_reg == 3'h7))
    else $error("mask-all did not load 7");

  chk_mask_plus_one: assert property (take_irq |=>
    (mask_reg == (($past(arb_bus.win_lvl) >= 3'h6) ? 3'h7 : $past(arb_bus.win_lvl) + 3'h1)))
    else $error("mask after acceptance wrong");

  chk_trap_keeps_mask: assert property (take_trap |=> $stable(mask_reg) && !vector_ack)
    else $error("trap touched mask or vector read");

  chk_accept_level: assert property (take_irq |->
    (arb_bus.win_lvl > mask_reg) || (arb_bus.win_idx == '0))
    else $error("accepted level not above mask");

  chk_nest_inc: assert property ((take_irq || take_trap) && (nest_reg != '1) |=>
    (nest_reg == $past(nest_reg) + 1'b1) && stack_push)
    else $error("nesting counter not incremented");

  chk_return_from_interrupt_instr_pop: assert property (do_return_from_interrupt_instr && (nest_reg != '0) |=>
    (nest_reg == $past(nest_reg) - 1'b1) && stack_pop)
    else $error("return did not pop and decrement");

  chk_len_16_16: assert property ((take_irq || take_trap) && stack_bus16 && vector_bus16
    |-> ##25 seq_end)
    else $error("acceptance not 25 states");

  chk_len_8_8: assert property ((take_irq || take_trap) && !stack_bus16 && !vector_bus16
    |-> ##35 seq_end)
    else $error("acceptance not 35 states");

  chk_winner_clear: assert property (take_irq && !set_vec[arb_bus.win_idx] |=>
    !req_reg[$past(arb_bus.win_idx)] && (vector_value == entry_vec($past(arb_bus.win_idx))))
    else $error("winner not delivered and cleared");

  chk_handler_table: assert property (handler_go |->
    (handler_addr[23:8] == 16'hffff) && !accept_busy)
    else $error("handler address outside table");

  chk_pend_holds: assert property (!take_irq && !clr_we |=> (($past(req_reg) & ~req_reg) == '0))
    else $error("request dropped while pending");

  cov_nested: cover property (seq_end && take_irq);
  cov_trap_masked: cover property (take_trap && (mask_reg == 3'h7));
  cov_nmi_masked: cover property (take_irq && (arb_bus.win_idx == '0) && (mask_reg == 3'h7));
  cov_handler: cover property (handler_go);

endmodule : pia_top

/* File: verification/pia_cpu_model.sv */
`timescale 1ns/1ps
// behavioural cpu core: keeps the stacked mask, runs handlers, returns
module pia_cpu_model (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       stack_push,
  input  wire logic       handler_go,
  input  wire logic       accept_busy,
  input  wire logic [2:0] cpu_interrupt_mask,
  input  wire logic [3:0] ret_dly,
  output logic            return_from_interrupt_instr,
  output logic [2:0]      return_mask_value
);
  logic [2:0] stk[$];     // stacked status, mask part only
  logic [2:0] prev_mask;  // mask seen one cycle before the push
  logic [3:0] cnt;        // handler run time left
  ////////////////////////////////////////////////////////////////////
  // push on acceptance, pop and return after a handler has run
  always @(posedge clk) begin
    if (!resetn) begin
      stk.delete();
      prev_mask                   <= 3'h7;
      cnt                         <= 4'h0;
      return_from_interrupt_instr <= 1'b0;
      return_mask_value           <= 3'h0;
    end else begin
      // old mask is the one in the status word
      if (stack_push) stk.push_back(prev_mask);
      prev_mask <= cpu_interrupt_mask;
      if (handler_go) begin
        cnt <= ret_dly;
      end else if (!accept_busy && stk.size() > 0 && !return_from_interrupt_instr) begin
        // outer handlers finish too, one return each
        if (cnt == 4'h0) begin
          cnt <= ret_dly;
        end else begin
          cnt <= cnt - 4'h1;
        end
      end
      if (!handler_go && !accept_busy && stk.size() > 0 && !return_from_interrupt_instr &&
          cnt == 4'h0) begin
        return_from_interrupt_instr <= 1'b1;
        return_mask_value           <= stk.pop_back();
      end else begin
        return_from_interrupt_instr <= 1'b0;
        return_mask_value           <= ~return_mask_value; // inverted each idle cycle: no stale value held
      end
    end
  end
endmodule : pia_cpu_model

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  typedef struct {
    bit         trap;
    logic [7:0] vec;
    logic [7:0] dma;
    logic [2:0] mask;
    logic [7:0] nest;
    int         states;
  } pia_note_s;
  logic clk, resetn, nmi_req, cfg_we, clr_we, mask_set_instr, mask_all_instr;
  logic software_trap_instr, return_from_interrupt_instr, stack_bus16, vector_bus16;
  logic [21:0] chan_req;
  logic [4:0]  cfg_chan, clr_chan;
  logic [2:0]  cfg_level, mask_set_value, return_mask_value, irq_level, cpu_interrupt_mask;
  logic [7:0]  cfg_dma_vec, trap_vector, interrupt_nesting_counter, vector_value;
  logic [7:0]  dma_start_vector;
  logic        irq_request, vector_ack, stack_push, stack_pop, accept_busy, handler_go;
  logic [23:0] handler_addr;
  logic [3:0]  ret_dly;      // handler run time of the cpu model
  pia_note_s   q[$];         // expected acceptances, oldest first
  int          n_fail, comparisons;
  ////////////////////////////////////////////////////////////////////
  pia_top DUT (.clk, .resetn, .nmi_req, .chan_req, .cfg_we, .cfg_chan, .cfg_level,
    .cfg_dma_vec, .clr_we, .clr_chan, .mask_set_instr, .mask_set_value, .mask_all_instr,
    .software_trap_instr, .trap_vector, .return_from_interrupt_instr, .return_mask_value,
    .stack_bus16, .vector_bus16, .irq_request, .irq_level, .cpu_interrupt_mask,
    .interrupt_nesting_counter, .vector_ack, .vector_value, .dma_start_vector,
    .stack_push, .stack_pop, .accept_busy, .handler_go, .handler_addr);
  pia_cpu_model u_cpu (.clk, .resetn, .stack_push, .handler_go, .accept_busy,
    .cpu_interrupt_mask, .ret_dly, .return_from_interrupt_instr, .return_mask_value);
  // 40 mhz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////
  task chk(input logic [23:0] act, input logic [23:0] exp, input string what);
    comparisons++;
    if (act !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, act, exp);
    end
  endtask : chk
  task final_report;
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  // acceptance length by bus widths
  function int states(input logic s16, input logic v16);
    return s16 ? (v16 ? 25 : 29) : (v16 ? 31 : 35);
  endfunction : states
  // mask after acceptance, saturating at 7
  function logic [2:0] sat(input logic [2:0] l);
    return (l == 3'h7) ? 3'h7 : l + 3'h1;
  endfunction : sat
  function logic [7:0] vec(input int ch);
    return pia_pkg::VEC_CHAN_BASE + 8'(4 * ch);
  endfunction : vec
  ////////////////////////////////////////////////////////////////////
  task cfg(input int ch, input logic [2:0] l, input logic [7:0] d);
    @(posedge clk);
    cfg_we <= 1'b1; cfg_chan <= 5'(ch); cfg_level <= l; cfg_dma_vec <= d;
    @(posedge clk);
    cfg_we <= 1'b0;
  endtask : cfg
  // one-cycle request pulses
  task req(input logic [21:0] m, input logic nmi);
    @(posedge clk);
    chan_req <= m; nmi_req <= nmi;
    @(posedge clk);
    chan_req <= '0; nmi_req <= 1'b0;
  endtask : req
  // k: 0 mask set, 1 mask all, 2 trap, 3 clear latch
  task pulse(input int k, input logic [7:0] v);
    @(posedge clk);
    mask_set_value <= v[2:0]; trap_vector <= v; clr_chan <= v[4:0];
    case (k)
      0: mask_set_instr <= 1'b1;
      1: mask_all_instr <= 1'b1;
      2: software_trap_instr <= 1'b1;
      default: clr_we <= 1'b1;
    endcase
    @(posedge clk);
    {mask_set_instr, mask_all_instr, software_trap_instr, clr_we} <= '0;
  endtask : pulse
  // bounded wait until all expected acceptances returned
  task wait_quiet;
    int n;
    n = 0;
    while (n < 3000 && (accept_busy !== 1'b0 || interrupt_nesting_counter !== 8'h00
           || q.size() != 0 || u_cpu.stk.size() != 0)) begin
      @(posedge clk);
      n++;
    end
    chk(24'(n >= 3000), 24'h0, "quiet timeout");
    repeat (3) @(posedge clk);
    #1;
    chk(24'(q.size()), 24'h0, "acceptances missing");
  endtask : wait_quiet
  ////////////////////////////////////////////////////////////////////
  // monitor: each push takes the oldest note, then times the handler branch
  initial begin
    pia_note_s n;
    int        gcnt;
    logic      ret_seen;
    gcnt = 0;
    ret_seen = 1'b0;
    n = '{0, 8'h00, 8'h00, 3'h0, 8'h00, 0};
    forever begin
      @(posedge clk);
      #1;
      if (resetn === 1'b1) begin
        gcnt++;
        chk(stack_pop, ret_seen, "return pop");
        ret_seen = return_from_interrupt_instr;
        if (stack_push === 1'b1) begin
          gcnt = 0;
          if (q.size() == 0) begin
            chk(24'h1, 24'h0, "unexpected acceptance");
          end else begin
            n = q.pop_front();
            chk(vector_ack, !n.trap, "vector read");
            if (!n.trap) chk(vector_value, n.vec, "vector");
            if (!n.trap) chk(dma_start_vector, n.dma, "transfer vector");
            chk(cpu_interrupt_mask, n.mask, "mask after accept");
            chk(interrupt_nesting_counter, n.nest, "nesting");
          end
        end
        if (handler_go === 1'b1) begin
          chk(24'(gcnt), 24'(n.states), "acceptance length");
          chk(handler_addr, {16'hffff, n.vec}, "handler entry");
        end
      end
    end
  end
  // watchdog
  initial begin
    #(25ns * 20000);
    n_fail++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    logic [2:0] lvl;
    logic [7:0] d3, d7;
    {nmi_req, cfg_we, clr_we, mask_set_instr, mask_all_instr, software_trap_instr} = '0;
    chan_req = '0; cfg_chan = '0; cfg_level = '0; cfg_dma_vec = '0; clr_chan = '0;
    mask_set_value = '0; trap_vector = '0; stack_bus16 = 1'b0; vector_bus16 = 1'b0;
    ret_dly = 4'h0; resetn = 1'b0; n_fail = 0; comparisons = 0;
    void'($urandom(49));
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    chk(cpu_interrupt_mask, 3'h7, "reset mask");
    chk(interrupt_nesting_counter, 8'h00, "reset nesting");
    // equal-level tie and refusal, all four bus width pairs
    for (int i = 0; i < 4; i++) begin
      lvl = 3'(1 + $urandom % 6);
      d3 = 8'($urandom);
      d7 = 8'($urandom);
      @(posedge clk);
      {stack_bus16, vector_bus16} <= 2'(i);
      ret_dly <= 4'($urandom % 16);
      cfg(3, lvl, d3);
      cfg(7, lvl, d7);
      pulse(0, 8'(lvl));
      #1 chk(cpu_interrupt_mask, lvl, "mask set");
      req(22'h000088, 1'b0);
      repeat (4) @(posedge clk);
      #1 chk(irq_level, lvl, "presented level");
      chk(irq_request, 1'b0, "same level refused");
      q.push_back('{0, vec(3), d3, sat(lvl), 8'h01, states(i[1], i[0])});
      q.push_back('{0, vec(7), d7, sat(lvl), 8'h01, states(i[1], i[0])});
      pulse(0, 8'(lvl - 3'h1));
      wait_quiet();
      chk(cpu_interrupt_mask, lvl - 3'h1, "mask restored");
    end
    // latch pends at mask 7, then software clear
    pulse(1, 8'h00);
    #1 chk(cpu_interrupt_mask, 3'h7, "mask all");
    cfg(12, 3'h3, 8'h00);
    req(22'h001000, 1'b0);
    repeat (3) @(posedge clk);
    #1 chk(irq_level, 3'h3, "pending level");
    pulse(3, 8'd12);
    repeat (3) @(posedge clk);
    #1 chk(irq_level, 3'h0, "cleared level");
    // non-maskable at mask 7, then a trap at mask 7
    q.push_back('{0, pia_pkg::VEC_NMI, 8'h00, 3'h7, 8'h01, 25});
    req(22'h0, 1'b1);
    wait_quiet();
    lvl = 3'h7;
    d3 = 8'($urandom) & 8'hfc;
    q.push_back('{1, d3, 8'h00, 3'h7, 8'h01, 25});
    pulse(2, d3);
    wait_quiet();
    chk(cpu_interrupt_mask, 3'h7, "mask after traps");
    // higher request during the sequence nests before the handler
    cfg(2, 3'h2, 8'h11);
    cfg(9, 3'h5, 8'h22);
    pulse(0, 8'h00);
    q.push_back('{0, vec(2), 8'h11, 3'h3, 8'h01, 25});
    q.push_back('{0, vec(9), 8'h22, 3'h6, 8'h02, 25});
    req(22'h000004, 1'b0);
    for (int n = 0; n < 20 && stack_push !== 1'b1; n++) @(posedge clk);
    repeat (5) @(posedge clk);
    req(22'h000200, 1'b0);
    wait_quiet();
    chk(cpu_interrupt_mask, 3'h0, "mask after nesting");
    final_report();
  end
endmodule : tb_top
